// file: rtl/core_special_register_file.sv
// General and special register file of the processor core
`timescale 1ns/1ns
module core_special_register_file #(
   parameter logic [core_regs_pkg::VER_OWNER_W-1:0] OWNER_ID = 12'h5A5,
   parameter logic [core_regs_pkg::VER_FAM_W-1:0] FAMILY_ID = 4'h1,
   parameter logic [core_regs_pkg::VER_CAS_W-1:0] CACHE_SIZES = 6'h00,
   parameter logic [core_regs_pkg::VER_REV_W-1:0] CORE_REV = 4'h1,
   parameter logic [core_regs_pkg::VER_ASIC_W-1:0] ASIC_NUM = 6'h01,
   parameter int GPR_COUNT = 32,
   parameter int SCR_COUNT = 8
) (
   // Clock, reset, enable
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // General register ports
   input wire logic [core_regs_pkg::GPR_AW-1:0] gpr_ra_addr_in,
   input wire logic [core_regs_pkg::GPR_AW-1:0] gpr_rb_addr_in,
   input wire logic gpr_we_in,
   input wire logic [core_regs_pkg::GPR_AW-1:0] gpr_wr_addr_in,
   input wire logic [core_regs_pkg::XLEN-1:0] gpr_wr_data_in,
   output logic [core_regs_pkg::XLEN-1:0] gpr_ra_data_out,
   output logic [core_regs_pkg::XLEN-1:0] gpr_rb_data_out,
   // Special register moves and time reads
   input wire logic spr_req_in,
   input wire logic spr_write_in,
   input wire logic [core_regs_pkg::SPR_NW-1:0] spr_num_in,
   input wire logic [core_regs_pkg::XLEN-1:0] spr_wdata_in,
   input wire logic user_mode_in,
   input wire logic tbr_req_in,
   input wire logic tbr_upper_in,
   input wire logic [core_regs_pkg::XLEN-1:0] time_lower_word_in,
   input wire logic [core_regs_pkg::XLEN-1:0] time_upper_word_in,
   output logic [core_regs_pkg::XLEN-1:0] spr_rdata_out,
   output logic spr_done_out,
   output logic priv_viol_out,
   output logic time_wr_lower_out,
   output logic time_wr_upper_out,
   output logic [core_regs_pkg::XLEN-1:0] time_wdata_out,
   // Branch unit
   input wire logic link_bit_in,
   input wire logic [core_regs_pkg::XLEN-1:0] br_next_addr_in,
   input wire logic ctr_dec_in,
   output logic [core_regs_pkg::XLEN-1:0] loop_counter_out,
   output logic ctr_zero_out,
   output logic [core_regs_pkg::XLEN-1:0] return_target_out,
   // Arithmetic flag updates
   input wire logic ca_upd_in,
   input wire logic ov_upd_in,
   input wire logic carry_into_msb_in,
   input wire logic carry_out_msb_in,
   input wire logic cond_copy_in,
   output logic summary_ovf_out,
   output logic result_too_large_flag_out,
   output logic msb_out_bit_flag_out,
   output logic [core_regs_pkg::LEN_W-1:0] string_length_field_out,
   output logic [core_regs_pkg::COND_W-1:0] cond_field_out
);
   localparam logic [core_regs_pkg::XLEN-1:0] VERSION_VALUE =
      {OWNER_ID, FAMILY_ID, CACHE_SIZES, CORE_REV, ASIC_NUM};

   logic [core_regs_pkg::XLEN-1:0] general_register [GPR_COUNT];
   logic [core_regs_pkg::XLEN-1:0] scratch [SCR_COUNT];
   logic [core_regs_pkg::XLEN-1:0] user_scratch;
   logic [core_regs_pkg::XLEN-1:0] return_link;
   logic [core_regs_pkg::XLEN-1:0] next_rdata;
   logic [core_regs_pkg::XLEN-1:0] next_ctr;
   logic spr_ok;
   logic spr_wr_go;
   logic spr_rd_go;
   logic st_wr;
   logic next_ov;
   logic next_ca;

   spr_dec_if dec_bus ();

   assign dec_bus.num = spr_num_in;
   assign dec_bus.wr = spr_write_in;
   assign dec_bus.user = user_mode_in;

   spr_decode u_dec (
      .d(dec_bus)
   );

   assign spr_ok = ce_in && spr_req_in && dec_bus.legal;
   assign spr_wr_go = spr_ok && spr_write_in;
   assign spr_rd_go = spr_ok && !spr_write_in;
   assign st_wr = spr_wr_go && dec_bus.sel == core_regs_pkg::SEL_STATUS;

   function automatic logic [core_regs_pkg::XLEN-1:0] gpr_fwd(
      input logic [core_regs_pkg::GPR_AW-1:0] a,
      input logic we,
      input logic [core_regs_pkg::GPR_AW-1:0] wa,
      input logic [core_regs_pkg::XLEN-1:0] wd,
      input logic [core_regs_pkg::XLEN-1:0] stored);
      gpr_fwd = (we && a == wa) ? wd : stored;
   endfunction

   // ****************************************
   // General registers
   // ****************************************
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < GPR_COUNT; i++) begin
            general_register[i] <= '0;
         end
      end else if (ce_in && gpr_we_in) begin
         general_register[gpr_wr_addr_in] <= gpr_wr_data_in; // [RQ1]
      end
   end

   // Same-cycle write is forwarded so the read never sees stale data
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         gpr_ra_data_out <= '0;
         gpr_rb_data_out <= '0;
      end else if (ce_in) begin
         gpr_ra_data_out <= gpr_fwd(gpr_ra_addr_in, gpr_we_in,
            gpr_wr_addr_in, gpr_wr_data_in, general_register[gpr_ra_addr_in]); // [RQ1]
         gpr_rb_data_out <= gpr_fwd(gpr_rb_addr_in, gpr_we_in,
            gpr_wr_addr_in, gpr_wr_data_in, general_register[gpr_rb_addr_in]);
      end
   end

   // ****************************************
   // Scratch registers
   // ****************************************
   generate
      for (genvar g = 0; g < SCR_COUNT; g++) begin : g_scr
         always_ff @(posedge core_clk_in) begin
            if (!rstn_in) begin
               scratch[g] <= '0;
            end else if (spr_wr_go &&
                         dec_bus.sel == core_regs_pkg::SEL_SCR &&
                         dec_bus.idx == core_regs_pkg::SCR_AW'(g)) begin
               scratch[g] <= spr_wdata_in; // [RQ18]
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         user_scratch <= '0;
      end else if (spr_wr_go && dec_bus.sel == core_regs_pkg::SEL_USCR) begin
         user_scratch <= spr_wdata_in; // [RQ17] [RQ18]
      end
   end

   // ****************************************
   // Loop counter and return link
   // ****************************************
   // A move wins over a decrement; both never come from one instruction
   always_comb begin
      next_ctr = loop_counter_out - core_regs_pkg::XLEN'(1);
      if (spr_wr_go && dec_bus.sel == core_regs_pkg::SEL_COUNT) begin
         next_ctr = spr_wdata_in;
      end else if (!ctr_dec_in) begin
         next_ctr = loop_counter_out;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         loop_counter_out <= '0;
         ctr_zero_out <= 1'b0;
      end else if (ce_in) begin
         loop_counter_out <= next_ctr; // [RQ6]
         ctr_zero_out <= next_ctr == '0; // [RQ6]
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         return_link <= '0;
      end else if (spr_wr_go && dec_bus.sel == core_regs_pkg::SEL_LINK) begin
         return_link <= spr_wdata_in; // [RQ7]
      end else if (ce_in && link_bit_in) begin
         return_link <= br_next_addr_in; // [RQ7]
      end
   end

   // Target copy lags the stored link by nothing: both load together
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         return_target_out <= '0;
      end else if (spr_wr_go && dec_bus.sel == core_regs_pkg::SEL_LINK) begin
         return_target_out <= {spr_wdata_in[core_regs_pkg::XLEN-1:
            core_regs_pkg::LINK_LOW_ZERO],
            core_regs_pkg::LINK_LOW_ZERO'(0)}; // [RQ8]
      end else if (ce_in && link_bit_in) begin
         return_target_out <= {br_next_addr_in[core_regs_pkg::XLEN-1:
            core_regs_pkg::LINK_LOW_ZERO],
            core_regs_pkg::LINK_LOW_ZERO'(0)}; // [RQ8]
      end
   end

   // ****************************************
   // Fixed-point status flags
   // ****************************************
   assign next_ov = carry_into_msb_in ^ carry_out_msb_in; // [RQ12]
   assign next_ca = carry_out_msb_in; // [RQ13]

   // Priority: status move, then condition copy, then arithmetic
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         summary_ovf_out <= 1'b0;
         result_too_large_flag_out <= 1'b0;
         msb_out_bit_flag_out <= 1'b0;
         string_length_field_out <= '0;
         cond_field_out <= '0;
      end else if (st_wr) begin
         summary_ovf_out <= spr_wdata_in[core_regs_pkg::ST_SO_POS]; // [RQ11]
         result_too_large_flag_out <=
            spr_wdata_in[core_regs_pkg::ST_OV_POS]; // [RQ11] [RQ15]
         msb_out_bit_flag_out <=
            spr_wdata_in[core_regs_pkg::ST_CA_POS]; // [RQ14]
         string_length_field_out <= spr_wdata_in[core_regs_pkg::ST_LEN_HI:
            core_regs_pkg::ST_LEN_LO]; // [RQ11] [RQ16]
      end else if (ce_in && cond_copy_in) begin
         cond_field_out <= {summary_ovf_out, result_too_large_flag_out,
            msb_out_bit_flag_out, 1'b0}; // [RQ20]
         summary_ovf_out <= 1'b0; // [RQ10] [RQ20]
         result_too_large_flag_out <= 1'b0;
         msb_out_bit_flag_out <= 1'b0; // [RQ14]
      end else if (ce_in) begin
         if (ov_upd_in) begin
            result_too_large_flag_out <= next_ov; // [RQ12] [RQ15]
            if (next_ov) begin
               summary_ovf_out <= 1'b1; // [RQ9] [RQ10]
            end
         end
         if (ca_upd_in) begin
            msb_out_bit_flag_out <= next_ca; // [RQ13] [RQ14]
         end
      end
   end

   // ****************************************
   // Special register reads and answers
   // ****************************************
   // Time words read as zero through the special path; reserved bits zero
   always_comb begin
      next_rdata = '0;
      case (dec_bus.sel)
         core_regs_pkg::SEL_STATUS: begin
            next_rdata[core_regs_pkg::ST_SO_POS] = summary_ovf_out;
            next_rdata[core_regs_pkg::ST_OV_POS] = result_too_large_flag_out;
            next_rdata[core_regs_pkg::ST_CA_POS] = msb_out_bit_flag_out;
            next_rdata[core_regs_pkg::ST_LEN_HI:core_regs_pkg::ST_LEN_LO] =
               string_length_field_out; // [RQ16]
         end
         core_regs_pkg::SEL_LINK: next_rdata = return_link; // [RQ8]
         core_regs_pkg::SEL_COUNT: next_rdata = loop_counter_out;
         core_regs_pkg::SEL_USCR: next_rdata = user_scratch;
         core_regs_pkg::SEL_SCR: next_rdata = scratch[dec_bus.idx];
         core_regs_pkg::SEL_VERSION: next_rdata = VERSION_VALUE; // [RQ19] [RQ21]
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         spr_rdata_out <= '0;
         spr_done_out <= 1'b0;
         priv_viol_out <= 1'b0;
      end else if (ce_in) begin
         spr_done_out <= spr_ok || tbr_req_in;
         priv_viol_out <= spr_req_in && !dec_bus.legal; // [RQ4]
         if (tbr_req_in) begin
            spr_rdata_out <= tbr_upper_in ? time_upper_word_in :
               time_lower_word_in; // [RQ5]
         end else if (spr_rd_go) begin
            spr_rdata_out <= next_rdata; // [RQ22]
         end
      end
   end

   // Time words live in the timer; only the two write strobes and the write data leave here
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         time_wr_lower_out <= 1'b0;
         time_wr_upper_out <= 1'b0;
         time_wdata_out <= '0;
      end else if (ce_in) begin
         time_wr_lower_out <= spr_wr_go &&
            dec_bus.sel == core_regs_pkg::SEL_TIME_LO; // [RQ5]
         time_wr_upper_out <= spr_wr_go &&
            dec_bus.sel == core_regs_pkg::SEL_TIME_HI;
         if (spr_wr_go) begin
            time_wdata_out <= spr_wdata_in;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);

   chk_user_priv_viol: assert property ( // [RQ4]
      ce_in && spr_req_in && user_mode_in &&
      dec_bus.sel == core_regs_pkg::SEL_VERSION
      |=> priv_viol_out && !time_wr_lower_out)
      else $error("user version access not refused");
   chk_priv_no_viol: assert property ( // [RQ3]
      ce_in && spr_req_in && !user_mode_in |=> !priv_viol_out)
      else $error("privileged access refused");
   chk_time_write_user: assert property ( // [RQ5]
      ce_in && spr_req_in && spr_write_in && user_mode_in &&
      dec_bus.sel == core_regs_pkg::SEL_TIME_LO
      |=> !time_wr_lower_out && priv_viol_out)
      else $error("user time write not refused");
   chk_ctr_decrement: assert property ( // [RQ6]
      ce_in && ctr_dec_in && !spr_req_in
      |=> loop_counter_out == $past(loop_counter_out) - 32'h1 &&
      ctr_zero_out == (loop_counter_out == '0))
      else $error("loop counter decrement wrong");
   chk_link_load: assert property ( // [RQ7] [RQ8]
      ce_in && link_bit_in && !spr_req_in
      |=> return_link == $past(br_next_addr_in) &&
      return_target_out[core_regs_pkg::XLEN-1:core_regs_pkg::LINK_LOW_ZERO]
      == return_link[core_regs_pkg::XLEN-1:core_regs_pkg::LINK_LOW_ZERO])
      else $error("link load wrong");
   chk_link_read_whole: assert property ( // [RQ8] [RQ22]
      spr_wr_go && dec_bus.sel == core_regs_pkg::SEL_LINK ##1
      spr_rd_go && dec_bus.sel == core_regs_pkg::SEL_LINK && !tbr_req_in
      |=> spr_rdata_out == $past(spr_wdata_in, 2))
      else $error("link read not as written");
   chk_ov_sets_so: assert property ( // [RQ9] [RQ12]
      ce_in && ov_upd_in && (carry_into_msb_in != carry_out_msb_in) &&
      !st_wr && !cond_copy_in
      |=> (summary_ovf_out && result_too_large_flag_out) [*1] ##1
      (summary_ovf_out || $past(st_wr) || $past(ce_in && cond_copy_in)))
      else $error("overflow did not set summary");
   chk_so_sticky: assert property ( // [RQ10]
      summary_ovf_out && !st_wr && !(ce_in && cond_copy_in)
      |=> summary_ovf_out)
      else $error("summary overflow lost");
   chk_carry_update: assert property ( // [RQ13]
      ce_in && ca_upd_in && !st_wr && !cond_copy_in
      |=> msb_out_bit_flag_out == $past(carry_out_msb_in))
      else $error("carry flag wrong");
   chk_copy_clears: assert property ( // [RQ20]
      ce_in && cond_copy_in && !st_wr
      |=> cond_field_out == {$past(summary_ovf_out),
      $past(result_too_large_flag_out), $past(msb_out_bit_flag_out), 1'b0}
      && !summary_ovf_out && !msb_out_bit_flag_out)
      else $error("condition copy wrong");
   chk_version_ro: assert property ( // [RQ19] [RQ21]
      spr_wr_go && dec_bus.sel == core_regs_pkg::SEL_VERSION ##1
      spr_rd_go && dec_bus.sel == core_regs_pkg::SEL_VERSION && !tbr_req_in
      |=> spr_rdata_out == VERSION_VALUE)
      else $error("version register changed");
endmodule

// file: common/core_regs_pkg.sv
// Constants and types shared by the core special register file
// Operation
// [RQ1] Thirty-two 32-bit general registers, read and written
// [RQ2] Software writes zero to reserved fields
// [RQ3] User mode reaches only count, link, status, scratch
// [RQ4] User access to privileged register raises violation
// [RQ5] Time words: privileged write-only, time reads free
// [RQ6] Loop counter written, decremented, tested, branch target
// [RQ7] Linking branch loads next instruction address
// [RQ8] Link target drops two low bits, reads whole
// [RQ9] Overflow set also sets summary overflow
// [RQ10] Summary overflow sticky until explicit clear
// [RQ11] Status write loads summary, overflow, length
// [RQ12] Overflow equals carry-in xor carry-out of top bit
// [RQ13] Carry equals carry out of top bit
// [RQ14] Carry updated only by its instruction group
// [RQ15] Overflow flags updated only by overflow forms
// [RQ16] Status layout: flags, reserved, seven-bit length
// [RQ17] User scratch free in user mode
// [RQ18] Scratch registers hold software values untouched
// [RQ19] Version register read-only and privileged
// [RQ20] Condition copy moves flags out, then clears
// [RQ21] Write to version register changes nothing
// [RQ22] Special writes visible to the next access
package core_regs_pkg;
   localparam int XLEN = 32;
   localparam int GPR_AW = 5;
   localparam int SPR_NW = 10;
   localparam int SCR_AW = 3;
   localparam int LEN_W = 7;
   localparam int COND_W = 4;
   localparam int LINK_LOW_ZERO = 2;
   // ****************************************
   // Special register numbers
   // ****************************************
   localparam logic [SPR_NW-1:0] SPRN_STATUS = 10'h001;
   localparam logic [SPR_NW-1:0] SPRN_LINK = 10'h008;
   localparam logic [SPR_NW-1:0] SPRN_COUNT = 10'h009;
   localparam logic [SPR_NW-1:0] SPRN_USER_SCR = 10'h100;
   localparam logic [SPR_NW-4:0] SPRN_SCR_HI = 7'h22;
   localparam logic [SPR_NW-1:0] SPRN_TIME_LO = 10'h11C;
   localparam logic [SPR_NW-1:0] SPRN_TIME_HI = 10'h11D;
   localparam logic [SPR_NW-1:0] SPRN_VERSION = 10'h11F;
   localparam logic [SCR_AW-1:0] SCR_USER_READ_MIN = 3'h4;
   // ****************************************
   // Status register layout, bit 31 is the msb
   // ****************************************
   localparam int ST_SO_POS = 31;
   localparam int ST_OV_POS = 30;
   localparam int ST_CA_POS = 29;
   localparam int ST_LEN_HI = 6;
   localparam int ST_LEN_LO = 0;
   // ****************************************
   // Version register field widths
   // ****************************************
   localparam int VER_OWNER_W = 12;
   localparam int VER_FAM_W = 4;
   localparam int VER_CAS_W = 6;
   localparam int VER_REV_W = 4;
   localparam int VER_ASIC_W = 6;
   typedef enum logic [3:0] {
      SEL_NONE, SEL_STATUS, SEL_LINK, SEL_COUNT, SEL_USCR,
      SEL_SCR, SEL_VERSION, SEL_TIME_LO, SEL_TIME_HI
   } spr_sel_t;
endpackage

// file: common/spr_dec_if.sv
// Decode request and answer between core and special decoder
`timescale 1ns/1ns
interface spr_dec_if;
   logic [core_regs_pkg::SPR_NW-1:0] num;
   logic wr;
   logic user;
   core_regs_pkg::spr_sel_t sel;
   logic [core_regs_pkg::SCR_AW-1:0] idx;
   logic legal;
   modport dec (input num, wr, user, output sel, idx, legal);
   modport core (output num, wr, user, input sel, idx, legal);
endinterface

// file: rtl/spr_decode.sv
// Special register number decode and privilege check
`timescale 1ns/1ns
module spr_decode (
   spr_dec_if.dec d
);
   function automatic logic user_ok(
      input core_regs_pkg::spr_sel_t s,
      input logic w,
      input logic [core_regs_pkg::SCR_AW-1:0] i);
      user_ok = (s == core_regs_pkg::SEL_COUNT) ||
         (s == core_regs_pkg::SEL_LINK) ||
         (s == core_regs_pkg::SEL_STATUS) ||
         (s == core_regs_pkg::SEL_USCR) ||
         (s == core_regs_pkg::SEL_SCR && !w &&
          i >= core_regs_pkg::SCR_USER_READ_MIN); // [RQ3] [RQ17]
   endfunction

   always_comb begin
      d.idx = d.num[core_regs_pkg::SCR_AW-1:0];
      if (d.num[core_regs_pkg::SPR_NW-1:core_regs_pkg::SCR_AW] ==
          core_regs_pkg::SPRN_SCR_HI) begin
         d.sel = core_regs_pkg::SEL_SCR;
      end else begin
         case (d.num)
            core_regs_pkg::SPRN_STATUS: d.sel = core_regs_pkg::SEL_STATUS;
            core_regs_pkg::SPRN_LINK: d.sel = core_regs_pkg::SEL_LINK;
            core_regs_pkg::SPRN_COUNT: d.sel = core_regs_pkg::SEL_COUNT;
            core_regs_pkg::SPRN_USER_SCR: d.sel = core_regs_pkg::SEL_USCR;
            core_regs_pkg::SPRN_TIME_LO: d.sel = core_regs_pkg::SEL_TIME_LO;
            core_regs_pkg::SPRN_TIME_HI: d.sel = core_regs_pkg::SEL_TIME_HI;
            core_regs_pkg::SPRN_VERSION: d.sel = core_regs_pkg::SEL_VERSION;
            default: d.sel = core_regs_pkg::SEL_NONE;
         endcase
      end
      // Unknown numbers are privileged too, so user code cannot probe
      d.legal = !d.user || user_ok(d.sel, d.wr, d.idx); // [RQ3] [RQ5]
   end
endmodule

// file: verification/exec_unit_model.sv
// Execution unit model driving branch and arithmetic flag inputs
`timescale 1ns/1ns
module exec_unit_model (
   // Random word from the bench
   input wire logic [31:0] rnd_in,
   // Branch and flag requests
   output logic ca_upd_out,
   output logic ov_upd_out,
   output logic cin_out,
   output logic cout_out,
   output logic link_out,
   output logic dec_out,
   output logic [31:0] next_addr_out
);
   // Follows the bench word, so it only moves at the falling edge
   always_comb begin
      ca_upd_out = rnd_in[20];
      ov_upd_out = rnd_in[21];
      cin_out = rnd_in[22];
      cout_out = rnd_in[23];
      link_out = rnd_in[24] & rnd_in[25];
      dec_out = rnd_in[26];
      next_addr_out = {rnd_in[29:0], 2'b00};
   end
endmodule

// file: verification/tb_core_special_register_file.sv
// Random self-checking bench for the core special register file
`timescale 1ns/1ns
module tb_core_special_register_file;
   // Arbitrary identity values, not those of any real part
   localparam logic [31:0] VER = {12'h3C7, 4'h2, 6'h05, 4'h3, 6'h09};
   logic clk, rstn, ce, we, req, w, usr, tbr, tup, cp;
   logic cau, ovu, ci, co, lk, dec;
   logic [4:0] raa, rba, wa;
   logic [9:0] n;
   logic [9:0] nums [16];
   logic [31:0] wd, d, tlw, tuw, nxt, r, pr, v;
   logic [31:0] ra_o, rb_o, rd_o, twd_o, ctr_o, tgt_o;
   logic dn_o, vi_o, twl_o, twu_o, zr_o, so_o, ov_o, ca_o;
   logic [6:0] len_o;
   logic [3:0] cf_o;
   // Bench model state
   logic [31:0] g [32];
   logic [31:0] scr [8];
   logic [31:0] ra, rb, ctr, lr, us, rd, twd;
   logic so, ov, ca, dn, vi, tl, tu, zr, ok;
   logic [6:0] len;
   logic [3:0] cf;
   int num_errors = 0;
   int check_count = 0;
   int cyc = 0;
   core_special_register_file #(.OWNER_ID(12'h3C7), .FAMILY_ID(4'h2),
      .CACHE_SIZES(6'h05), .CORE_REV(4'h3), .ASIC_NUM(6'h09)) dut (
      .core_clk_in(clk), .rstn_in(rstn), .ce_in(ce),
      .gpr_ra_addr_in(raa), .gpr_rb_addr_in(rba), .gpr_we_in(we),
      .gpr_wr_addr_in(wa), .gpr_wr_data_in(wd),
      .gpr_ra_data_out(ra_o), .gpr_rb_data_out(rb_o),
      .spr_req_in(req), .spr_write_in(w), .spr_num_in(n),
      .spr_wdata_in(d), .user_mode_in(usr), .tbr_req_in(tbr),
      .tbr_upper_in(tup), .time_lower_word_in(tlw),
      .time_upper_word_in(tuw), .spr_rdata_out(rd_o),
      .spr_done_out(dn_o), .priv_viol_out(vi_o),
      .time_wr_lower_out(twl_o), .time_wr_upper_out(twu_o),
      .time_wdata_out(twd_o), .link_bit_in(lk), .br_next_addr_in(nxt),
      .ctr_dec_in(dec), .loop_counter_out(ctr_o), .ctr_zero_out(zr_o),
      .return_target_out(tgt_o), .ca_upd_in(cau), .ov_upd_in(ovu),
      .carry_into_msb_in(ci), .carry_out_msb_in(co), .cond_copy_in(cp),
      .summary_ovf_out(so_o), .result_too_large_flag_out(ov_o),
      .msb_out_bit_flag_out(ca_o), .string_length_field_out(len_o),
      .cond_field_out(cf_o));
   exec_unit_model partner (.rnd_in(pr), .ca_upd_out(cau),
      .ov_upd_out(ovu), .cin_out(ci), .cout_out(co), .link_out(lk),
      .dec_out(dec), .next_addr_out(nxt));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // **************************************
   // Model, updated on the edge that takes the inputs
   // **************************************
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         num_errors++;
         complete_run();
      end
      if (!rstn) begin
         foreach (g[i]) g[i] = 0;
         foreach (scr[i]) scr[i] = 0;
         {ra, rb, ctr, lr, us, rd, twd} = '0;
         {so, ov, ca, dn, vi, tl, tu, zr, len, cf} = '0;
      end else if (ce) begin
         ra = (we && wa == raa) ? wd : g[raa];
         rb = (we && wa == rba) ? wd : g[rba];
         if (we) g[wa] = wd;
         {dn, vi, tl, tu} = '0;
         case (n)
            core_regs_pkg::SPRN_STATUS: v = {so, ov, ca, 22'h0, len};
            core_regs_pkg::SPRN_LINK: v = lr;
            core_regs_pkg::SPRN_COUNT: v = ctr;
            core_regs_pkg::SPRN_USER_SCR: v = us;
            core_regs_pkg::SPRN_VERSION: v = VER;
            default: v = (n[9:3] == core_regs_pkg::SPRN_SCR_HI) ?
               scr[n[2:0]] : 32'h0;
         endcase
         ok = !usr || n == core_regs_pkg::SPRN_STATUS ||
            n == core_regs_pkg::SPRN_LINK || n == core_regs_pkg::SPRN_COUNT
            || n == core_regs_pkg::SPRN_USER_SCR ||
            (!w && n[9:3] == core_regs_pkg::SPRN_SCR_HI && n[2]);
         if (cp) begin
            cf = {so, ov, ca, 1'b0};
            {so, ov, ca} = '0;
         end else begin
            if (ovu) ov = ci ^ co;
            if (ovu && ov) so = 1'b1;
            if (cau) ca = co;
         end
         if (dec) ctr = ctr - 1;
         if (lk) lr = nxt;
         if (req && !ok) vi = 1'b1;
         if (req && ok) dn = 1'b1;
         if (req && ok && !w && !tbr) rd = v;
         if (req && ok && w) begin
            case (n)
               core_regs_pkg::SPRN_STATUS: {so, ov, ca, len} = {d[31:29], d[6:0]};
               core_regs_pkg::SPRN_LINK: lr = d;
               core_regs_pkg::SPRN_COUNT: ctr = d;
               core_regs_pkg::SPRN_USER_SCR: us = d;
               core_regs_pkg::SPRN_TIME_LO: {tl, twd} = {1'b1, d};
               core_regs_pkg::SPRN_TIME_HI: {tu, twd} = {1'b1, d};
               default: if (n[9:3] == core_regs_pkg::SPRN_SCR_HI) scr[n[2:0]] = d;
            endcase
         end
         zr = (ctr == 0);
         if (tbr) {dn, rd} = {1'b1, tup ? tuw : tlw};
      end
   end
   initial begin
      nums = '{core_regs_pkg::SPRN_STATUS, core_regs_pkg::SPRN_LINK,
         core_regs_pkg::SPRN_COUNT, core_regs_pkg::SPRN_USER_SCR,
         10'h110, 10'h111, 10'h112, 10'h113, 10'h114, 10'h115, 10'h116,
         10'h117, core_regs_pkg::SPRN_TIME_LO, core_regs_pkg::SPRN_TIME_HI,
         core_regs_pkg::SPRN_VERSION, 10'h3FF};
      r = 32'h69B9B579;
      {rstn, ce, we, req, w, usr, tbr, tup, cp, raa, rba, wa, n} = '0;
      {wd, d, tlw, tuw, pr} = '0;
      repeat (10) @(negedge clk);
      for (int i = 0; i < 3000; i++) begin
         @(negedge clk);
         rstn = 1'b1;
         if (i > 0) begin
            chk("gpr_a", ra_o, ra);
            chk("gpr_b", rb_o, rb);
            chk("rdata", rd_o, rd);
            chk("done", dn_o, dn);
            chk("viol", vi_o, vi);
            chk("time_wr", {twl_o, twu_o}, {tl, tu});
            if (tl || tu) chk("time_data", twd_o, twd);
            chk("counter", ctr_o, ctr);
            chk("ctr_zero", zr_o, zr);
            chk("target", tgt_o, lr & 32'hFFFFFFFC);
            chk("flags", {so_o, ov_o, ca_o, len_o}, {so, ov, ca, len});
            chk("cond", cf_o, cf);
         end
         if (i == 1500) rstn = 1'b0;
         r = xs(r);
         ce = |r[31:29];
         {req, w, usr} = {r[0], r[1], r[2] & r[3]};
         n = nums[r[7:4]];
         tbr = !req && r[8];
         tup = r[9];
         r = xs(r);
         // Reserved status bits go out as zero, counter kept small
         d = (n == core_regs_pkg::SPRN_STATUS) ? r & 32'hE000007F : r;
         if (n == core_regs_pkg::SPRN_COUNT) d = r & 32'h3;
         {tlw, tuw} = {r, ~r};
         r = xs(r);
         {raa, rba, we, wa} = r[15:0];
         cp = r[16] & r[17] & !(req && w && n == core_regs_pkg::SPRN_STATUS);
         wd = xs(r);
         pr = r;
      end
      complete_run();
   end
endmodule
